// ---- core/smq_core.sv ----
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module smq_core import smq_pkg::*; (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    smq_state_s  st;
    smq_state_s  st_nxt;
    logic        exec_go;
    logic [32:0] old_word;
    logic [32:0] rd_word;
    logic [31:0] wr_word;
    smq_op_e     op;
    logic [4:0]  n;
    logic [31:0] rot;
    logic [31:0] mask;
    logic [31:0] res;

    ////////////////////////////////////////////////////////////////////////////////

    // Bit 32 of the result flags an unmapped offset.
    function automatic logic [32:0] rd_mux(input smq_state_s s, input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = '0;
        case (a)
            OFF_INSN: r[31:0] = s.insn;
            OFF_SRC:  r[31:0] = s.src;
            OFF_CNT:  r[31:0] = s.cnt;
            OFF_MQ:   r[31:0] = s.mq;
            OFF_TGT:  r[31:0] = s.tgt;
            OFF_CR0:  r[3:0]  = s.cr0;
            OFF_XER:  r[31:0] = s.xer;
            OFF_STAT: begin
                r[ST_OK]  = s.last_ok;
                r[ST_BAD] = s.last_bad;
            end
            default:  r[32] = 1'b1;
        endcase
        return r;
    endfunction : rd_mux

    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] d,
                                               input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] k);
        logic [63:0] t;
        t = {x, x} << k;
        return t[63:32];
    endfunction : rotl

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt   = st;
        exec_go  = 1'b0;
        old_word = rd_mux(st, st.waddr);
        wr_word  = strb_merge(old_word[31:0], st.wdata, st.wstrb);
        rd_word  = rd_mux(st, s_axi_araddr);
        op       = OP_NONE;
        n        = wr_word[CNT_HI:CNT_LO];
        rot      = '0;
        mask     = '0;
        res      = '0;

        // Write address and data are taken independently, in either order.
        if (st.aw_rdy && s_axi_awvalid) begin
            st_nxt.aw_ok = 1'b1;
            st_nxt.waddr = s_axi_awaddr;
        end
        if (st.w_rdy && s_axi_wvalid) begin
            st_nxt.w_ok  = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st.aw_ok && st.w_ok && !st.bvalid) begin
            st_nxt.aw_ok  = 1'b0;
            st_nxt.w_ok   = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = old_word[32] ? RESP_SLVERR : RESP_OKAY;
            // Read-only words accept the write and ignore it.
            case (st.waddr)
                OFF_INSN: begin
                    st_nxt.insn = wr_word;
                    exec_go     = 1'b1;
                end
                OFF_SRC: st_nxt.src = wr_word;
                OFF_CNT: st_nxt.cnt = wr_word;
                OFF_MQ:  st_nxt.mq  = wr_word;
                OFF_XER: st_nxt.xer = wr_word;
                default: ;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        st_nxt.aw_rdy = !st_nxt.aw_ok && !st_nxt.bvalid;
        st_nxt.w_rdy  = !st_nxt.w_ok && !st_nxt.bvalid;

        // Decode runs on every write word; only exec_go lets it act.
        if (wr_word[OPCD_HI:OPCD_LO] == OPCD_X) begin
            case (wr_word[XO_HI:XO_LO])
                XO_IMM_MASK:  op = OP_IMM_MASK;  // [RULE_01]
                XO_IMM_MERGE: op = OP_IMM_MERGE; // [RULE_03]
                XO_REG_MERGE: op = OP_REG_MERGE; // [RULE_05]
                default:      op = OP_NONE;
            endcase
        end
        if (op == OP_REG_MERGE) begin
            n = st.cnt[N_HI:N_LO]; // [RULE_06]
        end
        rot = rotl(st.src, n);
        case (op)
            OP_IMM_MASK: begin
                mask = ONES << n;
                res  = rot & mask; // [RULE_02]
            end
            OP_IMM_MERGE: begin
                mask = ONES << n;
                res  = (rot & mask) | (st.mq & ~mask); // [RULE_04] [RULE_12]
            end
            OP_REG_MERGE: begin
                if (!st.cnt[SEL_BIT]) begin
                    mask = ONES >> n;
                    res  = (rot & mask) | (st.mq & ~mask); // [RULE_07] [RULE_12]
                end else begin
                    mask = ~(ONES >> n);
                    res  = st.mq & ~mask; // [RULE_08] [RULE_12]
                end
            end
            default: res = '0;
        endcase

        // The exception word is only ever written from the bus. [RULE_11]
        if (exec_go) begin
            st_nxt.last_ok  = (op != OP_NONE);
            st_nxt.last_bad = (op == OP_NONE);
            if (op != OP_NONE) begin
                st_nxt.tgt = res;
                if (op != OP_REG_MERGE) begin
                    st_nxt.mq = rot; // [RULE_02] [RULE_04] [RULE_09]
                end
                if (wr_word[RC_BIT]) begin
                    st_nxt.cr0[CR_LT] = res[31]; // [RULE_10]
                    st_nxt.cr0[CR_GT] = !res[31] && (|res);
                    st_nxt.cr0[CR_EQ] = ~|res;
                    st_nxt.cr0[CR_SO] = st.xer[XER_SO_BIT]; // [RULE_13]
                end
            end
        end

        // Reads are answered one cycle after the address is taken.
        if (st.ar_rdy && s_axi_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word[31:0];
            st_nxt.rresp  = rd_word[32] ? RESP_SLVERR : RESP_OKAY;
        end
        if (st.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.ar_rdy = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= ST_RST;
        end else begin
            st <= st_nxt;
        end
    end

    assign s_axi_awready = st.aw_rdy;
    assign s_axi_wready  = st.w_rdy;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.ar_rdy;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    ////////////////////////////////////////////////////////////////////////////////

    // An independent rotate form, so a slip in rotl shows up.
    logic [4:0]  chk_n;
    logic [31:0] chk_rot;
    logic        xer_wr;
    assign chk_n   = (op == OP_REG_MERGE) ? st.cnt[N_HI:N_LO] : wr_word[CNT_HI:CNT_LO];
    assign chk_rot = (st.src << chk_n) | (st.src >> (6'd32 - {1'b0, chk_n}));
    assign xer_wr  = st.aw_ok && st.w_ok && !st.bvalid && (st.waddr == OFF_XER);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dec_imm_mask;
        exec_go && wr_word[OPCD_HI:OPCD_LO] == OPCD_X && wr_word[XO_HI:XO_LO] == XO_IMM_MASK
            |=> st.last_ok && !st.last_bad;
    endproperty
    a_dec_imm_mask: assert property (p_dec_imm_mask) else $error("imm mask not decoded"); // [RULE_01]

    property p_imm_mask;
        exec_go && op == OP_IMM_MASK
            |=> st.mq == $past(chk_rot) && st.tgt == ($past(chk_rot) & (ONES << $past(chk_n)));
    endproperty
    a_imm_mask: assert property (p_imm_mask) else $error("imm mask result wrong"); // [RULE_02]

    property p_dec_imm_merge;
        exec_go && wr_word[OPCD_HI:OPCD_LO] == OPCD_X && wr_word[XO_HI:XO_LO] == XO_IMM_MERGE
            |=> st.last_ok;
    endproperty
    a_dec_imm_merge: assert property (p_dec_imm_merge) else $error("imm merge not decoded"); // [RULE_03]

    property p_imm_merge;
        exec_go && op == OP_IMM_MERGE
            |=> st.mq == $past(chk_rot)
                && ((st.tgt ^ $past(st.mq)) & ~(ONES << $past(chk_n))) == 32'h0
                && ((st.tgt ^ $past(chk_rot)) & (ONES << $past(chk_n))) == 32'h0;
    endproperty
    a_imm_merge: assert property (p_imm_merge) else $error("imm merge result wrong"); // [RULE_04]

    property p_dec_reg_merge;
        exec_go && wr_word[OPCD_HI:OPCD_LO] == OPCD_X && wr_word[XO_HI:XO_LO] == XO_REG_MERGE
            |=> st.last_ok ##1 st.last_ok;
    endproperty
    a_dec_reg_merge: assert property (p_dec_reg_merge) else $error("reg merge not decoded"); // [RULE_05]

    property p_reg_sel0;
        exec_go && op == OP_REG_MERGE && !st.cnt[SEL_BIT]
            |=> st.tgt == (($past(chk_rot) & (ONES >> $past(chk_n)))
                           | ($past(st.mq) & ~(ONES >> $past(chk_n))));
    endproperty
    a_reg_sel0: assert property (p_reg_sel0) else $error("reg merge select 0 wrong"); // [RULE_07]

    property p_reg_sel1;
        exec_go && op == OP_REG_MERGE && st.cnt[SEL_BIT]
            |=> st.tgt == ($past(st.mq) & (ONES >> $past(chk_n)));
    endproperty
    a_reg_sel1: assert property (p_reg_sel1) else $error("reg merge select 1 wrong"); // [RULE_08]

    property p_reg_keep_mq;
        exec_go && op == OP_REG_MERGE |=> $stable(st.mq);
    endproperty
    a_reg_keep_mq: assert property (p_reg_keep_mq) else $error("quotient changed"); // [RULE_09]

    property p_cr0_keep;
        exec_go && !wr_word[RC_BIT] |=> $stable(st.cr0);
    endproperty
    a_cr0_keep: assert property (p_cr0_keep) else $error("cr0 changed without record"); // [RULE_10]

    property p_xer_keep;
        !xer_wr |=> $stable(st.xer);
    endproperty
    a_xer_keep: assert property (p_xer_keep) else $error("exception word changed"); // [RULE_11]

    property p_cr0_rec;
        exec_go && wr_word[RC_BIT] && op != OP_NONE
            |=> st.cr0[CR_SO] == $past(st.xer[XER_SO_BIT]) && st.cr0[CR_LT] == st.tgt[31]
                && st.cr0[CR_EQ] == (st.tgt == 32'h0);
    endproperty
    a_cr0_rec: assert property (p_cr0_rec) else $error("cr0 record wrong"); // [RULE_13]

    c_imm_mask:  cover property (exec_go && op == OP_IMM_MASK && wr_word[RC_BIT]);
    c_imm_merge: cover property (exec_go && op == OP_IMM_MERGE);
    c_reg_sel1:  cover property (exec_go && op == OP_REG_MERGE && st.cnt[SEL_BIT]);
    c_bad_op:    cover property (exec_go && op == OP_NONE);

endmodule : smq_core

`default_nettype wire

// ---- shared/smq_pkg.sv ----
// Operation
// (RULE_01) Opcode 31, extended 184: immediate rotate-mask.
// (RULE_02) Rotated word to quotient, masked word to target.
// (RULE_03) Opcode 31, extended 248: immediate rotate-merge.
// (RULE_04) Merge rotated with quotient; rotated word to quotient.
// (RULE_05) Opcode 31, extended 216: register-count merge.
// (RULE_06) Count from count bits 27-31, bit 26 selects.
// (RULE_07) Select 0: zeros-then-ones mask merges rotated word.
// (RULE_08) Select 1: ones-then-zeros mask merges zero word.
// (RULE_09) Register-count form leaves quotient register unchanged.
// (RULE_10) Record flag updates condition field 0 only.
// (RULE_11) Exception register never changed by these instructions.
// (RULE_12) Mask one takes operand; zero takes quotient bit.
// (RULE_13) Summary-overflow copied from exception register.
package smq_pkg;

    localparam int ADDR_W = 5;

    // Instruction fields, little-endian numbering of the 32-bit word.
    localparam int OPCD_HI = 31;
    localparam int OPCD_LO = 26;
    localparam int XO_HI   = 10;
    localparam int XO_LO   = 1;
    localparam int CNT_HI  = 15;
    localparam int CNT_LO  = 11;
    localparam int RC_BIT  = 0;
    localparam logic [5:0] OPCD_X       = 6'h1f;
    localparam logic [9:0] XO_IMM_MASK  = 10'h0b8;
    localparam logic [9:0] XO_IMM_MERGE = 10'h0f8;
    localparam logic [9:0] XO_REG_MERGE = 10'h0d8;

    // Count-holding word: count in the low five bits, select just above.
    localparam int N_HI    = 4;
    localparam int N_LO    = 0;
    localparam int SEL_BIT = 5;

    localparam int XER_SO_BIT = 31;
    localparam int CR_LT = 3;
    localparam int CR_GT = 2;
    localparam int CR_EQ = 1;
    localparam int CR_SO = 0;
    localparam int ST_OK  = 0;
    localparam int ST_BAD = 1;

    localparam logic [31:0] ONES = 32'hffff_ffff;

    localparam logic [ADDR_W-1:0] OFF_INSN = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_SRC  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_CNT  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MQ   = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_TGT  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_CR0  = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_XER  = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_STAT = 5'h1c;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_NONE, OP_IMM_MASK, OP_IMM_MERGE, OP_REG_MERGE} smq_op_e;

    typedef struct packed {
        logic              aw_rdy;
        logic              w_rdy;
        logic              aw_ok;
        logic              w_ok;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_rdy;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [31:0]       insn;
        logic [31:0]       src;
        logic [31:0]       cnt;
        logic [31:0]       mq;
        logic [31:0]       tgt;
        logic [31:0]       xer;
        logic [3:0]        cr0;
        logic              last_ok;
        logic              last_bad;
    } smq_state_s;

    localparam smq_state_s ST_RST = '0;

endpackage : smq_pkg

// ---- verification/smq_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module smq_host import smq_pkg::*; (
    input  wire logic              aclk,
    output logic [ADDR_W-1:0]      s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [31:0]            s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    output logic                   s_axi_bready,
    output logic [ADDR_W-1:0]      s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready,
    output logic                   hung
);

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end

    // Answers are taken promptly or after up to three idle cycles.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        int   k;
        int   dly;
        logic done;
        k = 0;
        dly = $urandom_range(3);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (dly == 0);
        do begin
            @(posedge aclk);
            k++;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
            s_axi_bready <= !done && (k >= dly);
        end while (!done && k < 200);
        r = s_axi_bresp;
        if (!done) hung <= 1'b1;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        int   k;
        int   dly;
        logic done;
        k = 0;
        dly = $urandom_range(3);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (dly == 0);
        do begin
            @(posedge aclk);
            k++;
            done = s_axi_rvalid && s_axi_rready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            s_axi_rready <= !done && (k >= dly);
        end while (!done && k < 200);
        if (!done) hung <= 1'b1;
    endtask : rd

endmodule : smq_host

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench import smq_pkg::*; ;

    logic              aclk, aresetn, hung;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, br;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, ok;
    int                n_errors, samples_checked, k;
    logic [33:0]       exp_q[$];
    logic [31:0]       src, cnt, mq, nmq, xer, tgt, rot, msk, insn;
    logic [5:0]        n;
    logic [3:0]        cr0;

    smq_core u_dut (.*);
    smq_host u_host (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] e);
        u_host.wr(a, d, br);
        chk("write response", {32'h0, br}, {32'h0, e});
    endtask : put

    task automatic get(input logic [ADDR_W-1:0] a, input logic [1:0] e, input logic [31:0] d);
        exp_q.push_back({e, d});
        u_host.rd(a);
    endtask : get

    // Every read result is judged here against the oldest note.
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_q.size() == 0) chk("spurious read", 34'h0, 34'h1);
            else chk("read word", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end

    always @(posedge hung) begin
        chk("bus wait", 34'h0, 34'h1);
        conclude();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {n_errors, samples_checked} = '0;
        {mq, xer, tgt, cr0} = '0;
        void'($urandom(17));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        get(OFF_TGT, RESP_OKAY, 32'h0);
        get(OFF_CR0, RESP_OKAY, 32'h0);
        for (int i = 0; i < 48; i++) begin
            k = i % 4;
            src = $urandom();
            nmq = $urandom();
            xer = $urandom();
            cnt = $urandom();
            if (i < 8) cnt[4:0] = (i < 4) ? 5'h00 : 5'h1f;
            insn = $urandom();
            insn[31:26] = (i % 8 == 3) ? 6'h1e : OPCD_X;
            insn[CNT_HI:CNT_LO] = cnt[4:0];
            case (k)
                0: insn[XO_HI:XO_LO] = XO_IMM_MASK;
                1: insn[XO_HI:XO_LO] = XO_IMM_MERGE;
                2: insn[XO_HI:XO_LO] = XO_REG_MERGE;
                default: insn[XO_HI:XO_LO] = (i % 8 == 3) ? XO_IMM_MASK : 10'h099;
            endcase
            ok = (k != 3);
            // Old quotient drives the merge; nmq ends up as the new one.
            mq = nmq;
            n = {1'b0, cnt[N_HI:N_LO]};
            rot = (src << n) | (src >> (6'd32 - n));
            msk = ONES << n;
            case (k)
                0: tgt = rot & msk;
                1: tgt = (rot & msk) | (mq & ~msk);
                2: tgt = cnt[SEL_BIT] ? (mq & (ONES >> n))
                       : ((rot & (ONES >> n)) | (mq & ~(ONES >> n)));
                default: tgt = tgt;
            endcase
            nmq = (k < 2) ? rot : mq;
            if (ok && insn[RC_BIT])
                cr0 = {tgt[31], !tgt[31] && tgt != 0, tgt == 0, xer[XER_SO_BIT]};
            put(OFF_SRC, src, RESP_OKAY);
            put(OFF_CNT, cnt, RESP_OKAY);
            put(OFF_MQ, mq, RESP_OKAY);
            put(OFF_XER, xer, RESP_OKAY);
            put(OFF_INSN, insn, RESP_OKAY);
            get(OFF_TGT, RESP_OKAY, tgt);
            get(OFF_MQ, RESP_OKAY, nmq);
            get(OFF_CR0, RESP_OKAY, {28'h0, cr0});
            get(OFF_XER, RESP_OKAY, xer);
            get(OFF_STAT, RESP_OKAY, ok ? 32'h1 : 32'h2);
        end
        // Read-only and misaligned places must leave the datapath alone.
        put(OFF_TGT, ~tgt, RESP_OKAY);
        put(5'h06, 32'h0, RESP_SLVERR);
        get(OFF_TGT, RESP_OKAY, tgt);
        get(5'h02, RESP_SLVERR, 32'h0);
        repeat (4) @(posedge aclk);
        chk("pending reads", {2'h0, 32'(exp_q.size())}, 34'h0);
        conclude();
    end

endmodule : testbench

`default_nettype wire
